// ### logic/node_status_led_driver.sv
// status indicator driver of a real-time ethernet controlled node:
// bus state duo indicator, bus fault duo indicator and per-channel
// link/activity indicators
// assumes all inputs synchronous to i_clock; indicators are active high
`timescale 1ns/100ps

// Notes on behaviour
// - steady green when operational; dark while initializing.
// - basic ethernet state shows the 10 Hz flicker.
// - fault indicator dark without error, steady red with error.
// - link without traffic lights the channel's green indicator steadily.
// - link with traffic makes the green indicator flicker with load.
// - no link keeps the channel's green indicator dark.
// - the yellow channel indicators stay dark always.
// - triple flash: three 200 ms pulses, 200 ms gaps, 1000 ms pause.
// - double flash: two 200 ms pulses, 200 ms gap, 1000 ms pause.
// - single flash: one 200 ms pulse then 1000 ms pause.
// - flicker is 50 ms on, 50 ms off.
// - flicker and blink alternate red and green, never both lit.
// - blinking is 200 ms on, 200 ms off.
// - load flicker about 50 ms on and off, irregular when light.
module node_status_led_driver #(
   parameter int unsigned MS_CYCLES = led_status_pkg::MS_CYCLES,
   parameter int unsigned NUM_CHANNELS = led_status_pkg::NUM_CHANNELS
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // node status
   input wire led_status_pkg::node_state_t i_node_state,
   input wire logic i_error,
   // ethernet channels
   input wire logic [NUM_CHANNELS-1:0] i_link,
   input wire logic [NUM_CHANNELS-1:0] i_activity,
   // duo indicators
   output led_status_pkg::led_pair_t o_bus_state_indicator,
   output led_status_pkg::led_pair_t o_bus_fault_indicator,
   // channel indicators
   output logic [NUM_CHANNELS-1:0] o_link_green,
   output logic [NUM_CHANNELS-1:0] o_link_yellow
);

   localparam int unsigned DIV_W = led_status_pkg::DIV_W;
   localparam int unsigned SEQ_W = led_status_pkg::SEQ_W;
   localparam int unsigned STEP_W = led_status_pkg::STEP_W;

   // =========================================================
   // state
   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic tick;
      led_status_pkg::node_state_t node;
      logic [STEP_W-1:0] step;
      logic [SEQ_W-1:0] cnt;
      led_status_pkg::led_pair_t bus_state;
      led_status_pkg::led_pair_t bus_fault;
   } drv_state_t;

   drv_state_t st_ff;
   drv_state_t nxt_st;

   // =========================================================
   // pattern selection
   led_status_pkg::pattern_t pattern;
   logic [STEP_W-1:0] last_step;
   logic [SEQ_W-1:0] step_len;
   logic step_lit;

   always_comb begin
      pattern = led_status_pkg::PAT_DARK;
      // two-step patterns wrap after step 1 as well
      last_step = led_status_pkg::LAST_SINGLE;
      case (st_ff.node)
         led_status_pkg::NODE_INIT: begin
            pattern = led_status_pkg::PAT_DARK;
         end
         led_status_pkg::NODE_OPERATIONAL: begin
            pattern = led_status_pkg::PAT_STEADY;
         end
         led_status_pkg::NODE_READY: begin
            pattern = led_status_pkg::PAT_FLASH;
            last_step = led_status_pkg::LAST_TRIPLE;
         end
         led_status_pkg::NODE_PRE_OP2: begin
            pattern = led_status_pkg::PAT_FLASH;
            last_step = led_status_pkg::LAST_DOUBLE;
         end
         led_status_pkg::NODE_PRE_OP1: begin
            pattern = led_status_pkg::PAT_FLASH;
            last_step = led_status_pkg::LAST_SINGLE;
         end
         led_status_pkg::NODE_BASIC_ETH: begin
            pattern = led_status_pkg::PAT_FLICKER;
         end
         led_status_pkg::NODE_STOPPED: begin
            pattern = led_status_pkg::PAT_BLINK;
         end
         default: begin
            pattern = led_status_pkg::PAT_DARK;
         end
      endcase
   end

   // =========================================================
   // step durations
   // even steps are lit, odd steps dark; the last flash step is the pause
   always_comb begin
      step_lit = ~st_ff.step[0];
      case (pattern)
         led_status_pkg::PAT_FLASH: begin
            if (st_ff.step >= last_step) begin
               step_len = led_status_pkg::FLASH_PAUSE_TICKS;
            end else if (step_lit) begin
               step_len = led_status_pkg::FLASH_ON_TICKS;
            end else begin
               step_len = led_status_pkg::FLASH_GAP_TICKS;
            end
         end
         led_status_pkg::PAT_FLICKER: begin
            step_len = led_status_pkg::FLICKER_TICKS;
         end
         led_status_pkg::PAT_BLINK: begin
            step_len = led_status_pkg::BLINK_TICKS;
         end
         default: begin
            step_len = led_status_pkg::FLASH_PAUSE_TICKS;
         end
      endcase
   end

   // =========================================================
   // next state
   always_comb begin
      nxt_st = st_ff;

      // millisecond time base
      nxt_st.tick = 1'b0;
      if (st_ff.div >= DIV_W'(MS_CYCLES - 1)) begin
         nxt_st.div = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.div = st_ff.div + 1'b1;
      end

      // pattern sequencer
      // a change is taken at once, so the new pattern never inherits
      // a half-finished step of the old one
      if (i_node_state != st_ff.node) begin
         nxt_st.node = i_node_state;
         nxt_st.step = led_status_pkg::STEP_FIRST;
         nxt_st.cnt = '0;
      end else if (st_ff.tick) begin
         if (st_ff.cnt >= step_len - 1'b1) begin
            nxt_st.cnt = '0;
            if (st_ff.step >= last_step) begin
               nxt_st.step = led_status_pkg::STEP_FIRST;
            end else begin
               nxt_st.step = st_ff.step + 1'b1;
            end
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end

      // bus state indicator
      case (pattern)
         led_status_pkg::PAT_STEADY: begin
            nxt_st.bus_state = '{red: 1'b0, green: 1'b1};
         end
         led_status_pkg::PAT_FLASH: begin
            // the pause step is odd and so already dark; the step check keeps it dark here
            nxt_st.bus_state.red = 1'b0;
            nxt_st.bus_state.green = step_lit &&
               (st_ff.step < last_step);
         end
         led_status_pkg::PAT_FLICKER,
         led_status_pkg::PAT_BLINK: begin
            nxt_st.bus_state.green = step_lit;
            nxt_st.bus_state.red = ~step_lit;
         end
         default: begin
            nxt_st.bus_state = '{red: 1'b0, green: 1'b0};
         end
      endcase

      // bus fault indicator
      nxt_st.bus_fault = '{red: i_error, green: 1'b0};
   end

   // =========================================================
   // registers
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_ff <= '{div: '0,
                    tick: 1'b0,
                    node: led_status_pkg::NODE_INIT,
                    step: led_status_pkg::STEP_RESET,
                    cnt: '0,
                    bus_state: '{red: 1'b0, green: 1'b0},
                    bus_fault: '{red: 1'b0, green: 1'b0}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_bus_state_indicator = st_ff.bus_state;
   assign o_bus_fault_indicator = st_ff.bus_fault;

   // =========================================================
   // channel indicators
   // every channel shares the one millisecond tick
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
      activity_flicker u_activity (
         .i_clock(i_clock),
         .i_rst(i_rst),
         .i_ms_tick(st_ff.tick),
         .i_link(i_link[ch]),
         .i_activity(i_activity[ch]),
         .o_led(o_link_green[ch])
      );
      // unused in this protocol mode
      assign o_link_yellow[ch] = 1'b0;
   end

endmodule : node_status_led_driver

// ### logic/led_status_pkg.sv
// shared types and constants of the node status indicator driver
// assumes a 40 MHz device clock; all pattern times count whole milliseconds
package led_status_pkg;

   // =========================================================
   // clock and time base
   localparam int unsigned CLOCK_HZ = 40_000_000;
   localparam int unsigned MS_PER_S = 1000;
   // cycles in one millisecond tick
   localparam int unsigned MS_CYCLES = CLOCK_HZ / MS_PER_S;
   localparam int unsigned DIV_W = 16;
   localparam int unsigned TICK_MS = 1;

   // =========================================================
   // pattern times in milliseconds
   localparam int unsigned FLASH_ON_MS = 200;
   localparam int unsigned FLASH_GAP_MS = 200;
   localparam int unsigned FLASH_PAUSE_MS = 1000;
   localparam int unsigned FLICKER_MS = 50;
   localparam int unsigned BLINK_MS = 200;
   localparam int unsigned LOAD_FLICKER_MS = 50;

   // =========================================================
   // pattern times in millisecond ticks
   localparam int unsigned SEQ_W = 10;
   localparam logic [SEQ_W-1:0] FLASH_ON_TICKS =
      SEQ_W'(FLASH_ON_MS / TICK_MS);
   localparam logic [SEQ_W-1:0] FLASH_GAP_TICKS =
      SEQ_W'(FLASH_GAP_MS / TICK_MS);
   localparam logic [SEQ_W-1:0] FLASH_PAUSE_TICKS =
      SEQ_W'(FLASH_PAUSE_MS / TICK_MS);
   localparam logic [SEQ_W-1:0] FLICKER_TICKS =
      SEQ_W'(FLICKER_MS / TICK_MS);
   localparam logic [SEQ_W-1:0] BLINK_TICKS =
      SEQ_W'(BLINK_MS / TICK_MS);
   localparam int unsigned LOAD_W = 6;
   localparam logic [LOAD_W-1:0] LOAD_TICKS =
      LOAD_W'(LOAD_FLICKER_MS / TICK_MS);

   // =========================================================
   // sequencer steps and channels
   localparam int unsigned STEP_W = 3;
   localparam logic [STEP_W-1:0] STEP_FIRST = 3'h0;
   // odd step, so dark in every flash pattern
   localparam logic [STEP_W-1:0] STEP_RESET = 3'h5;
   // last step of each flash sequence, the long dark pause
   localparam logic [STEP_W-1:0] LAST_TRIPLE = 3'h5;
   localparam logic [STEP_W-1:0] LAST_DOUBLE = 3'h3;
   localparam logic [STEP_W-1:0] LAST_SINGLE = 3'h1;
   localparam int unsigned NUM_CHANNELS = 2;

   // =========================================================
   // types
   typedef enum logic [2:0] {
      NODE_INIT        = 3'b000,
      NODE_PRE_OP1     = 3'b001,
      NODE_PRE_OP2     = 3'b010,
      NODE_READY       = 3'b011,
      NODE_OPERATIONAL = 3'b100,
      NODE_STOPPED     = 3'b101,
      NODE_BASIC_ETH   = 3'b110
   } node_state_t;

   typedef enum logic [2:0] {
      PAT_DARK    = 3'b000,
      PAT_STEADY  = 3'b001,
      PAT_FLASH   = 3'b010,
      PAT_FLICKER = 3'b011,
      PAT_BLINK   = 3'b100
   } pattern_t;

   typedef enum logic [1:0] {
      ACT_IDLE = 2'b00,
      ACT_OFF  = 2'b01,
      ACT_ON   = 2'b10
   } act_phase_t;

   typedef struct packed {
      logic red;
      logic green;
   } led_pair_t;

endpackage : led_status_pkg

// ### logic/activity_flicker.sv
// one channel's green link/activity indicator
// assumes a one-cycle millisecond tick and synchronous link/activity inputs
`timescale 1ns/100ps
module activity_flicker (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // time base
   input wire logic i_ms_tick,
   // channel status
   input wire logic i_link,
   input wire logic i_activity,
   // indicator
   output logic o_led
);

   typedef struct packed {
      led_status_pkg::act_phase_t phase;
      logic [led_status_pkg::LOAD_W-1:0] cnt;
      logic pend;
      logic led;
   } act_state_t;

   act_state_t st_ff;
   act_state_t nxt_st;

   // =========================================================
   // burst sequencer
   // each burst is one dark and one lit phase; back-to-back traffic
   // thus gives the regular flicker, sparse traffic irregular blips
   always_comb begin
      nxt_st = st_ff;
      // new traffic is remembered even while a burst is running
      nxt_st.pend = st_ff.pend | i_activity;
      case (st_ff.phase)
         led_status_pkg::ACT_IDLE: begin
            nxt_st.led = 1'b1;
            if (st_ff.pend) begin
               nxt_st.phase = led_status_pkg::ACT_OFF;
               nxt_st.cnt = '0;
               nxt_st.led = 1'b0;
               nxt_st.pend = i_activity; // set wins over clear
            end
         end
         led_status_pkg::ACT_OFF: begin
            nxt_st.led = 1'b0;
            if (i_ms_tick) begin
               if (st_ff.cnt >= led_status_pkg::LOAD_TICKS - 1'b1) begin
                  nxt_st.phase = led_status_pkg::ACT_ON;
                  nxt_st.cnt = '0;
                  nxt_st.led = 1'b1;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 1'b1;
               end
            end
         end
         led_status_pkg::ACT_ON: begin
            nxt_st.led = 1'b1;
            if (i_ms_tick) begin
               if (st_ff.cnt >= led_status_pkg::LOAD_TICKS - 1'b1) begin
                  nxt_st.phase = led_status_pkg::ACT_IDLE;
                  nxt_st.cnt = '0;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 1'b1;
               end
            end
         end
         default: begin
            nxt_st.phase = led_status_pkg::ACT_IDLE;
            nxt_st.cnt = '0;
         end
      endcase
      // without a link nothing is shown and old traffic is dropped
      if (!i_link) begin
         nxt_st.phase = led_status_pkg::ACT_IDLE;
         nxt_st.cnt = '0;
         nxt_st.pend = 1'b0;
         nxt_st.led = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_ff <= '{phase: led_status_pkg::ACT_IDLE, cnt: '0,
                    pend: 1'b0, led: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_led = st_ff.led;

endmodule : activity_flicker

// ### tb/led_panel_model.sv
// lamp panel model: counts lit cycles and green rises of a duo lamp
// and lit cycles of one channel lamp
// assumes the clear pulse is sampled on the rising clock edge
`timescale 1ns/100ps
module led_panel_model (
   // clock and control
   input wire logic i_clock,
   input wire logic i_clear,
   // lamps
   input wire led_status_pkg::led_pair_t i_duo,
   input wire logic i_lamp,
   // counts since the last clear
   output logic [31:0] o_green_on,
   output logic [31:0] o_red_on,
   output logic [31:0] o_rises,
   output logic [31:0] o_lamp_on
);
   logic green_ff;
   always_ff @(posedge i_clock) begin
      green_ff <= i_duo.green;
      if (i_clear) begin
         o_green_on <= '0;
         o_red_on <= '0;
         o_rises <= '0;
         o_lamp_on <= '0;
      end else begin
         o_green_on <= o_green_on + 32'(i_duo.green);
         o_red_on <= o_red_on + 32'(i_duo.red);
         o_rises <= o_rises + 32'(i_duo.green && !green_ff);
         o_lamp_on <= o_lamp_on + 32'(i_lamp);
      end
   end
endmodule : led_panel_model

// ### tb/node_status_led_driver_sva.sv
// checker of the node status indicator driver, sees its ports only
// assumes a synchronous active-high reset on i_clock
`timescale 1ns/100ps
module node_status_led_driver_sva #(
   parameter int unsigned MS_CYCLES = led_status_pkg::MS_CYCLES,
   parameter int unsigned NUM_CHANNELS = led_status_pkg::NUM_CHANNELS
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // watched ports
   input wire led_status_pkg::node_state_t i_node_state,
   input wire logic i_error,
   input wire logic [NUM_CHANNELS-1:0] i_link,
   input wire logic [NUM_CHANNELS-1:0] i_activity,
   input wire led_status_pkg::led_pair_t o_bus_state_indicator,
   input wire led_status_pkg::led_pair_t o_bus_fault_indicator,
   input wire logic [NUM_CHANNELS-1:0] o_link_green,
   input wire logic [NUM_CHANNELS-1:0] o_link_yellow
);
   // =========================================================
   // lit run length, cleared on a state change so that a steady
   // operational lamp never counts against the next pattern
   localparam int unsigned RUN_MAX = 201 * MS_CYCLES + 2;
   logic [31:0] run_ff;
   led_status_pkg::node_state_t last_ff;
   always_ff @(posedge i_clock) begin
      if (i_rst || !o_bus_state_indicator.green ||
          i_node_state != last_ff) begin
         run_ff <= '0;
      end else begin
         run_ff <= run_ff + 32'h1;
      end
      last_ff <= i_node_state;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // =========================================================
   // properties
   fault_follow_a: assert property (
      i_error |=> o_bus_fault_indicator.red)
      else $error("fault lamp dark after error");
   fault_clear_a: assert property (
      !i_error |=> !o_bus_fault_indicator.red)
      else $error("fault lamp lit without error");
   fault_green_a: assert property (!o_bus_fault_indicator.green)
      else $error("fault lamp shows green");
   yellow_dark_a: assert property (o_link_yellow == '0)
      else $error("yellow lamp lit");
   no_link_a: assert property (
      1'b1 |=> (o_link_green & ~$past(i_link)) == '0)
      else $error("channel lamp lit without link");
   both_lit_a: assert property (
      !(o_bus_state_indicator.red && o_bus_state_indicator.green))
      else $error("red and green lit together");
   oper_steady_a: assert property (
      (i_node_state == led_status_pkg::NODE_OPERATIONAL) [*5]
      |-> o_bus_state_indicator == 2'b01)
      else $error("operational lamp not steady green");
   init_dark_a: assert property (
      (i_node_state == led_status_pkg::NODE_INIT) [*5]
      |-> o_bus_state_indicator == 2'b00)
      else $error("state lamp lit while initializing");
   lit_run_a: assert property (
      run_ff <= 32'(RUN_MAX) ||
      i_node_state == led_status_pkg::NODE_OPERATIONAL)
      else $error("state lamp lit too long");
   reset_dark_a: assert property (
      $fell(i_rst) |-> o_bus_state_indicator == 2'b00 &&
      o_link_green == '0)
      else $error("lamps lit after reset");
endmodule : node_status_led_driver_sva

bind node_status_led_driver node_status_led_driver_sva #(
   .MS_CYCLES(MS_CYCLES),
   .NUM_CHANNELS(NUM_CHANNELS)
) checker_inst (
   .i_clock(i_clock),
   .i_rst(i_rst),
   .i_node_state(i_node_state),
   .i_error(i_error),
   .i_link(i_link),
   .i_activity(i_activity),
   .o_bus_state_indicator(o_bus_state_indicator),
   .o_bus_fault_indicator(o_bus_fault_indicator),
   .o_link_green(o_link_green),
   .o_link_yellow(o_link_yellow)
);

// ### tb/node_status_led_driver_bench.sv
// self-checking bench of the node status indicator driver
// assumes a shortened millisecond (M clocks) and the lamp panel model
`timescale 1ns/100ps
module node_status_led_driver_bench;
   localparam int M = 4;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   led_status_pkg::node_state_t i_node_state = led_status_pkg::NODE_INIT;
   logic i_error = 1'b0;
   logic [1:0] i_link = 2'h0;
   logic [1:0] i_activity = 2'h0;
   logic i_clear = 1'b0;
   led_status_pkg::led_pair_t o_bus_state_indicator, o_bus_fault_indicator;
   logic [1:0] o_link_green, o_link_yellow;
   logic [31:0] green_on, red_on, rises, lamp_on;
   int miscompares = 0;
   int check_count = 0;
   logic err_q;
   logic [1:0] link_q;
   led_status_pkg::node_state_t flash_st [3] = '{
      led_status_pkg::NODE_PRE_OP1, led_status_pkg::NODE_PRE_OP2,
      led_status_pkg::NODE_READY};
   led_status_pkg::node_state_t alt_st [2] = '{
      led_status_pkg::NODE_BASIC_ETH, led_status_pkg::NODE_STOPPED};
   int alt_half [2] = '{50, 200};

   node_status_led_driver #(.MS_CYCLES(M), .NUM_CHANNELS(2)) DUT (
      .i_clock(i_clock), .i_rst(i_rst), .i_node_state(i_node_state),
      .i_error(i_error), .i_link(i_link), .i_activity(i_activity),
      .o_bus_state_indicator(o_bus_state_indicator),
      .o_bus_fault_indicator(o_bus_fault_indicator),
      .o_link_green(o_link_green), .o_link_yellow(o_link_yellow));
   led_panel_model lamps (.i_clock(i_clock), .i_clear(i_clear),
      .i_duo(o_bus_state_indicator), .i_lamp(o_link_green[1]),
      .o_green_on(green_on), .o_red_on(red_on), .o_rises(rises),
      .o_lamp_on(lamp_on));

   // =========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // lamp timing shifts by up to one tick with the free-running divider
   function automatic logic near(input logic [31:0] v, e, t);
      return (v + t >= e) && (v <= e + t);
   endfunction : near
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clock);
   endtask : cyc
   task automatic run_state(input led_status_pkg::node_state_t s,
                            input int ms);
      cyc(1);
      i_node_state <= led_status_pkg::NODE_INIT;
      cyc(4);
      i_node_state <= s;
      i_clear <= 1'b1;
      cyc(1);
      i_clear <= 1'b0;
      cyc(ms * M - 1);
      #1;
   endtask : run_state
   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   // =========================================================
   // clock, watchdog and tests
   initial forever #12.5 i_clock = ~i_clock;
   initial begin
      // the tests need about 32000 clocks
      cyc(50000);
      miscompares++;
      print_verdict();
   end
   initial begin
      void'($urandom(60));
      cyc(20);
      i_rst <= 1'b0;
      err_q = 1'b0;
      link_q = 2'h0;
      repeat (300) begin
         cyc(1);
         i_error <= 1'($urandom);
         i_link <= 2'($urandom);
         #1;
         check(o_bus_fault_indicator, {err_q, 1'b0});
         check(o_link_green, link_q);
         check(o_link_yellow, 2'h0);
         // without traffic each lamp follows its link one clock later
         err_q = i_error;
         link_q = i_link;
      end
      for (int n = 1; n <= 3; n++) begin
         run_state(flash_st[n-1], 400 * n + 798);
         check(rises, n);
         check(near(green_on, 200 * n * M, M + 4), 1);
         check(red_on, 0);
      end
      cyc(1);
      i_node_state <= led_status_pkg::NODE_PRE_OP1;
      cyc(3);
      #1 check(o_bus_state_indicator, 2'b01);
      for (int k = 0; k < 2; k++) begin
         run_state(alt_st[k], 8 * alt_half[k] - 2);
         check(rises, 4);
         check(near(green_on, 4 * alt_half[k] * M, 3 * M), 1);
         check(near(red_on, 4 * alt_half[k] * M, 3 * M), 1);
      end
      run_state(led_status_pkg::NODE_OPERATIONAL, 100);
      check(near(green_on, 100 * M, 4), 1);
      check(red_on, 0);
      run_state(led_status_pkg::NODE_INIT, 100);
      check(green_on + red_on, 0);
      // the unused state code shows nothing either
      run_state(led_status_pkg::node_state_t'(3'h7), 50);
      check(green_on + red_on, 0);
      cyc(1);
      i_link <= 2'h2;
      i_activity <= 2'h3;
      i_clear <= 1'b1;
      cyc(1);
      i_clear <= 1'b0;
      cyc(400 * M);
      #1 check(near(lamp_on, 200 * M, 20 * M), 1);
      check(o_link_green[0], 0);
      cyc(1);
      i_activity <= 2'h0;
      cyc(250 * M);
      #1 check(o_link_green[1], 1);
      cyc(1);
      i_activity <= 2'h2;
      cyc(1);
      i_activity <= 2'h0;
      cyc(10);
      #1 check(o_link_green[1], 0);
      cyc(110 * M);
      #1 check(o_link_green[1], 1);
      print_verdict();
   end
endmodule : node_status_led_driver_bench
